/* hw/sswr_pkg.sv */
/*
 * Holds the shared constants of the supply supervisor and watchdog block.
 * Assumes a single 20 MHz clock that stands in for the internal time base.
 */
// Function
// - The reset output is only ever pulled low or released, and low means reset.
// - Reset is asserted while the rail comparator reports the rail below its threshold.
// - After the rail recovers or the watchdog expires, reset stays low for the full hold period.
// - Every rising and every falling edge of the strobe clears the watchdog counter.
// - When the watchdog counter reaches the timeout without a clear, reset is asserted.
// - While reset is asserted the watchdog counter is held cleared and does not count.
// - A floating or high-impedance strobe disables the watchdog entirely.
// - Reset is asserted while the manual reset input is held low.
// - After the manual reset input returns high, reset stays low for the full hold period.
// - Low-going glitches of up to about 100 ns on the manual reset input are ignored.
// - Reset is asserted at once when the input supply falls below the lockout level.
// - Below the lockout level reset is held low down to about one volt of supply.
package sswr_pkg;
    // Clock period in picoseconds, 20 MHz.
    localparam int CLK_PERIOD_PS = 50000;
    // Longest manual reset glitch to be ignored, in nanoseconds.
    localparam int MR_GLITCH_NS = 100;
    // Cycles a low must persist to count; one more than the glitch covers.
    localparam int MR_GLITCH_CYC =
        (MR_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    // Shortest strobe pulse that must be seen, in nanoseconds.
    localparam int WD_MIN_PULSE_NS = 80;
    // Default reset hold and watchdog timeout, in clock cycles.
    localparam int HOLD_CYC_DEF = 4000000;
    localparam int WD_CYC_DEF = 32000000;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [3:0] MR_ZERO = 4'h0;
    localparam logic [3:0] MR_ONE = 4'h1;
    // Output states of the reset sequencer.
    typedef enum logic [0:0] {SSWR_HOLD, SSWR_RUN} sswr_state_t;
endpackage

/* hw/sswr_top.sv */
/*
 * Supervisor logic: merges rail, lockout, manual and watchdog reset causes,
 * stretches them by a hold period and drives an open-drain reset pin.
 * The watchdog counts clock cycles between strobe edges and raises a
 * two-cycle expiry that the sequencer turns into a full reset pulse.
 * Checks on the cause logic, the counters and the pin sit at the end.
 * Assumes the analog comparators arrive as logic levels from other domains
 * and that a pad detector reports when the strobe pin is not driven.
 * Assumes an external pull-up on the reset pin; the pin is never driven
 * high, so the pull-up alone defines the released level.
 * Assumes the clock runs whenever the supply is above about one volt, so
 * the state register keeps the pin low through a supply collapse.
 */
`timescale 1ns/10ps
module sswr_top
    import sswr_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYC_DEF,
    parameter int WD_CYC = WD_CYC_DEF
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // Analog comparator levels, high means fault.
    input wire logic RAIL_LOW_IN,
    input wire logic SUPPLY_LOCKOUT_IN,
    // Processor side pins.
    input wire logic MANUAL_RESET_IN_N,
    input wire logic WATCHDOG_STROBE_IN,
    input wire logic WATCHDOG_STROBE_FLOAT_IN,
    // Open-drain reset pin.
    output logic PROCESSOR_RESET_OUT_N_O,
    output logic PROCESSOR_RESET_OUT_N_OE
);
    logic [1:0] rail_s_r, uvlo_s_r, mr_s_r, wdi_s_r, flt_s_r;
    logic wdi_d_r;
    logic [3:0] mr_cnt_r;
    logic mr_low_r;
    logic [CNT_W-1:0] wd_cnt_r, hold_cnt_r;
    logic wd_exp_r;
    sswr_state_t state_r;
    logic fault, wdi_edge, wd_off;

    // True when a count stands on the last cycle of a span of len cycles.
    function automatic logic at_end(logic [CNT_W-1:0] cnt, int len);
        return cnt == CNT_W'(len - 1);
    endfunction

    // Two-stage synchronisers for every external level.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rail_s_r <= 2'h3;
            uvlo_s_r <= 2'h3;
            mr_s_r <= 2'h3;
            wdi_s_r <= 2'h0;
            flt_s_r <= 2'h3;
        end else begin
            rail_s_r <= {rail_s_r[0], RAIL_LOW_IN};
            uvlo_s_r <= {uvlo_s_r[0], SUPPLY_LOCKOUT_IN};
            mr_s_r <= {mr_s_r[0], MANUAL_RESET_IN_N};
            wdi_s_r <= {wdi_s_r[0], WATCHDOG_STROBE_IN};
            flt_s_r <= {flt_s_r[0], WATCHDOG_STROBE_FLOAT_IN};
        end
    end

    // Manual reset debounce: a low counts only once it outlasts a glitch.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mr_cnt_r <= MR_ZERO;
            mr_low_r <= 1'b0;
        end else if (mr_s_r[1]) begin
            mr_cnt_r <= MR_ZERO;
            mr_low_r <= 1'b0;
        end else if (mr_cnt_r == 4'(MR_GLITCH_CYC - 1)) begin
            mr_low_r <= 1'b1;
        end else begin
            mr_cnt_r <= mr_cnt_r + MR_ONE;
        end
    end

    // Previous strobe level for edge detection.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdi_d_r <= 1'b0;
        end else begin
            wdi_d_r <= wdi_s_r[1];
        end
    end

    assign wdi_edge = wdi_s_r[1] ^ wdi_d_r;
    assign wd_off = flt_s_r[1];
    // Any cause that holds reset low; lockout acts without waiting.
    assign fault = rail_s_r[1] | uvlo_s_r[1] | mr_low_r | wd_exp_r;

    // Watchdog counter, cleared by edges, reset, or when disabled.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wd_cnt_r <= CNT_ZERO;
            wd_exp_r <= 1'b0;
        end else if (state_r == SSWR_HOLD || wd_off || wdi_edge) begin
            wd_cnt_r <= CNT_ZERO;
            wd_exp_r <= 1'b0;
        end else if (at_end(wd_cnt_r, WD_CYC)) begin
            wd_exp_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + CNT_ONE;
        end
    end

    // Reset sequencer: hold low while a fault stands, then for HOLD_CYC.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= SSWR_HOLD;
            hold_cnt_r <= CNT_ZERO;
        end else if (fault) begin
            state_r <= SSWR_HOLD;
            hold_cnt_r <= CNT_ZERO;
        end else begin
            unique case (state_r)
                SSWR_HOLD: begin
                    if (at_end(hold_cnt_r, HOLD_CYC)) begin
                        state_r <= SSWR_RUN;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + CNT_ONE;
                    end
                end
                SSWR_RUN: begin
                    hold_cnt_r <= CNT_ZERO;
                end
            endcase
        end
    end

    // Open drain: output value is always low, enable drives it.
    assign PROCESSOR_RESET_OUT_N_O = 1'b0;
    assign PROCESSOR_RESET_OUT_N_OE = (state_r == SSWR_HOLD);

    // Checks kept beside the logic.

    // Cycles since the last fault, saturating at the hold length.
    logic [CNT_W-1:0] quiet_cnt_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            quiet_cnt_r <= CNT_ZERO;
        end else if (fault) begin
            quiet_cnt_r <= CNT_ZERO;
        end else if (quiet_cnt_r != CNT_W'(HOLD_CYC)) begin
            quiet_cnt_r <= quiet_cnt_r + CNT_ONE;
        end
    end

    // The data side of the pin never carries a high level.
    a_never_high: assert property (
        @(posedge CLK) disable iff (!RST_N)
        PROCESSOR_RESET_OUT_N_O == 1'b0)
        else $error("reset pin driven high");

    // A low rail pulls the pin one cycle after it is seen.
    a_rail_asserts: assert property (
        @(posedge CLK) disable iff (!RST_N)
        rail_s_r[1] |=> PROCESSOR_RESET_OUT_N_OE)
        else $error("rail low did not assert reset");

    // Lockout pulls the pin with no debounce or delay of its own.
    a_uvlo_asserts: assert property (
        @(posedge CLK) disable iff (!RST_N)
        uvlo_s_r[1] |=> PROCESSOR_RESET_OUT_N_OE)
        else $error("lockout did not assert reset");

    // Release happens only from the last hold count.
    a_hold_full: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $rose(state_r == SSWR_RUN) |-> at_end(hold_cnt_r, HOLD_CYC))
        else $error("reset released before hold ended");

    // A released pin means a whole hold span passed without a fault.
    a_release_late: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !PROCESSOR_RESET_OUT_N_OE |-> quiet_cnt_r == CNT_W'(HOLD_CYC))
        else $error("reset released without a full hold");

    // Every strobe edge empties the watchdog count.
    a_edge_clears: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wdi_edge |=> wd_cnt_r == CNT_ZERO)
        else $error("strobe edge did not clear watchdog");

    // Expiry is turned into reset on the next cycle.
    a_wd_expiry: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wd_exp_r |=> PROCESSOR_RESET_OUT_N_OE)
        else $error("watchdog expiry did not reset");

    // An unserviced count on its last cycle raises expiry.
    a_wd_fires: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_RUN && !wd_off && !wdi_edge &&
        at_end(wd_cnt_r, WD_CYC) |=> wd_exp_r)
        else $error("watchdog did not expire on time");

    // An unserviced count below its end moves up by one.
    a_wd_counts: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_RUN && !wd_off && !wdi_edge &&
        !at_end(wd_cnt_r, WD_CYC) |=> wd_cnt_r == $past(wd_cnt_r) + CNT_ONE)
        else $error("watchdog count did not advance");

    // The count is held at zero while reset is active.
    a_wd_frozen: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_HOLD |=> wd_cnt_r == CNT_ZERO)
        else $error("watchdog counted during reset");

    // Expiry lasts two cycles; the reset it causes clears it.
    a_exp_clears: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wd_exp_r |-> ##2 !wd_exp_r)
        else $error("watchdog expiry not cleared by reset");

    // An undriven strobe pin keeps the watchdog idle.
    a_wd_disabled: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wd_off |=> !wd_exp_r && wd_cnt_r == CNT_ZERO)
        else $error("floating strobe did not disable watchdog");

    // A one-cycle low on the manual input is dropped.
    a_mr_glitch: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $fell(mr_s_r[1]) ##1 mr_s_r[1] |-> !mr_low_r)
        else $error("short manual reset glitch accepted");

    // A two-cycle low, the longest glitch, is dropped as well.
    a_mr_short: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $fell(mr_s_r[1]) ##1 !mr_s_r[1] ##1 mr_s_r[1] |-> !mr_low_r)
        else $error("two cycle manual glitch accepted");

    // Three synchronised low cycles are a real manual request.
    a_mr_accept: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !mr_s_r[1] [*3] |=> mr_low_r)
        else $error("held manual reset not accepted");

    // An accepted manual request pulls the pin.
    a_mr_asserts: assert property (
        @(posedge CLK) disable iff (!RST_N)
        mr_low_r |=> PROCESSOR_RESET_OUT_N_OE)
        else $error("manual reset did not assert reset");

    // Letting go of the button ends the request at once.
    a_mr_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        mr_s_r[1] |=> !mr_low_r)
        else $error("manual request outlived the button");

    // The pin is still low when the manual request ends.
    a_mr_release: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $fell(mr_low_r) |-> PROCESSOR_RESET_OUT_N_OE)
        else $error("manual release dropped reset at once");

    // Any standing cause keeps the pin low on the next cycle.
    a_fault_holds: assert property (
        @(posedge CLK) disable iff (!RST_N)
        fault |=> PROCESSOR_RESET_OUT_N_OE)
        else $error("standing fault let reset go");

    // A fault restarts the hold span from zero.
    a_hold_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        fault |=> hold_cnt_r == CNT_ZERO)
        else $error("fault did not restart the hold");

    // With no fault the hold count steps until its end.
    a_hold_counts: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_HOLD && !fault && !at_end(hold_cnt_r, HOLD_CYC)
        |=> hold_cnt_r == $past(hold_cnt_r) + CNT_ONE)
        else $error("hold count did not advance");

    // The hold count never passes its last value.
    a_hold_bound: assert property (
        @(posedge CLK) disable iff (!RST_N)
        hold_cnt_r <= CNT_W'(HOLD_CYC - 1))
        else $error("hold count out of range");

    // The watchdog count never passes its last value.
    a_wd_bound: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wd_cnt_r <= CNT_W'(WD_CYC - 1))
        else $error("watchdog count out of range");

    // Running means the rail was good on the cycle before.
    a_run_clean: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_RUN |-> !$past(rail_s_r[1]))
        else $error("running with the rail low");

    // Running means the supply was above lockout on the cycle before.
    a_lock_clean: assert property (
        @(posedge CLK) disable iff (!RST_N)
        state_r == SSWR_RUN |-> !$past(uvlo_s_r[1]))
        else $error("running below lockout");
endmodule

/* tb/sswr_cpu_model.sv */
/* Processor-side model: pull-up on the reset pin and a strobe driver.
   Assumes the bench sets the strobe period, zero meaning no toggling. */
`timescale 1ns/10ps
module sswr_cpu_model (
    // Controls.
    input wire logic clk,
    input wire logic drive_en,
    input wire logic [7:0] period,
    // Pins.
    input wire logic rst_o,
    input wire logic rst_oe,
    output logic rst_pin_n,
    output logic strobe,
    output logic strobe_float
);
    logic tog = 1'b0;
    int cnt = 0;
    // The pull-up wins whenever the pin is released.
    assign rst_pin_n = rst_oe ? rst_o : 1'b1;
    // A released strobe shows the inverse of its last level.
    assign strobe = drive_en ? tog : ~tog;
    assign strobe_float = ~drive_en;
    // Toggle once each period while driving.
    always @(negedge clk) begin
        cnt = (cnt + 1 >= period) ? 0 : cnt + 1;
        if (drive_en && period != 8'h00 && cnt == 0) tog <= ~tog;
    end
endmodule

/* tb/supply_supervisor_watchdog_reset_tb.sv */
/* Self-checking bench for the supervisor with a processor-side model.
   Assumes short hold and timeout counts and the designer's latencies. */
`timescale 1ns/10ps
module supply_supervisor_watchdog_reset_tb;
    localparam int HOLD = 20;
    localparam int WD = 50;
    logic clk = 1'b0, rst_n = 1'b0, rail = 1'b0, lock = 1'b0;
    logic man_n = 1'b1, drv = 1'b0, o, oe, pin_n, stb, flt;
    logic [7:0] per = 8'h10, lfsr = 8'h13;
    int err_count = 0, check_count = 0, n;
    // Free-running clock.
    always #25 clk = ~clk;
    sswr_top #(.HOLD_CYC(HOLD), .WD_CYC(WD)) sswr_top_inst (.CLK(clk),
        .RST_N(rst_n), .RAIL_LOW_IN(rail), .SUPPLY_LOCKOUT_IN(lock),
        .MANUAL_RESET_IN_N(man_n), .WATCHDOG_STROBE_IN(stb),
        .WATCHDOG_STROBE_FLOAT_IN(flt), .PROCESSOR_RESET_OUT_N_O(o),
        .PROCESSOR_RESET_OUT_N_OE(oe));
    sswr_cpu_model sswr_cpu_model_inst (.clk(clk), .drive_en(drv),
        .period(per), .rst_o(o), .rst_oe(oe), .rst_pin_n(pin_n),
        .strobe(stb), .strobe_float(flt));
    // Reference model from the rules: pins are seen two edges late.
    localparam int MR_LAST = sswr_pkg::MR_GLITCH_CYC - 1;
    logic [4:0] m_q[$];
    logic [4:0] m_s;
    logic m_run = 1'b0, m_prev = 1'b0, m_exp = 1'b0, m_low = 1'b0;
    logic m_fault;
    int m_cnt = 0, m_hold = 0, m_wd = 0;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q = '{5'h1d, 5'h1d};
            m_run = 1'b0;
            m_prev = 1'b0;
            m_exp = 1'b0;
            m_low = 1'b0;
            m_cnt = 0;
            m_hold = 0;
            m_wd = 0;
        end else begin
            m_q.push_back({rail, lock, man_n, stb, flt});
            m_s = m_q.pop_front();
            m_fault = m_s[4] | m_s[3] | m_low | m_exp;
            if (!m_run || m_s[0] || m_s[1] != m_prev) begin
                m_wd = 0;
                m_exp = 1'b0;
            end else if (m_wd == WD - 1) begin
                m_exp = 1'b1;
            end else begin
                m_wd++;
            end
            if (m_fault) begin
                m_run = 1'b0;
                m_hold = 0;
            end else if (!m_run && m_hold == HOLD - 1) begin
                m_run = 1'b1;
            end else if (!m_run) begin
                m_hold++;
            end
            if (m_s[2]) begin
                m_cnt = 0;
                m_low = 1'b0;
            end else if (m_cnt == MR_LAST) begin
                m_low = 1'b1;
            end else begin
                m_cnt++;
            end
            m_prev = m_s[1];
        end
    end
    function automatic logic [7:0] next_lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic idle(int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic chk(logic exp);
        check_count++;
        if (pin_n !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, pin_n, exp);
        end
        if (pin_n !== m_run) begin
            err_count++;
            $display("[ERR] t=%0t got %h model %h", $time, pin_n, m_run);
        end
    endtask
    // Compares the pin with the expected level on each of c cycles.
    task automatic hold(int c, logic exp);
        repeat (c) begin
            idle(1);
            chk(exp);
        end
    endtask
    task automatic set_fault(int k, logic v);
        case (k)
            0: rail = v;
            1: lock = v;
            default: man_n = ~v;
        endcase
    endtask
    task automatic conclude;
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        idle(6);
        rst_n = 1'b1;
        hold(HOLD - 4, 1'b0);
        idle(10);
        hold(20, 1'b1);
        for (int k = 0; k < 3; k++) begin
            set_fault(k, 1'b1);
            idle(8);
            hold(4, 1'b0);
            set_fault(k, 1'b0);
            hold(HOLD - 4, 1'b0);
            idle(16);
            chk(1'b1);
        end
        man_n = 1'b0;
        idle(2);
        man_n = 1'b1;
        hold(12, 1'b1);
        drv = 1'b1;
        repeat (4) begin
            lfsr = next_lfsr(lfsr);
            per = 8'h05 + (lfsr % 8'h1e);
            hold(100, 1'b1);
        end
        per = 8'h00;
        n = 0;
        while (pin_n !== 1'b0 && n < WD + 10) begin
            idle(1);
            n++;
        end
        chk(1'b0);
        hold(HOLD - 4, 1'b0);
        idle(10);
        hold(35, 1'b1);
        drv = 1'b0;
        hold(150, 1'b1);
        conclude();
    end
    // Watchdog against a hang.
    initial begin
        #250000;
        err_count++;
        conclude();
    end
endmodule
